//--- common/qcc_pkg.sv
// Constants, register map and carrier types of the quadrature counter/capture channel
package qcc_pkg;

   // Clock and sampling rates
   localparam int unsigned CLK_HZ   = 50_000_000;
   localparam int unsigned SLOW_HZ  = 32_000;
   localparam int unsigned SLOW_DIV = CLK_HZ / SLOW_HZ;
   localparam int unsigned HS_DIV   = 4;
   localparam int          SAMP_W   = 11;
   localparam logic [SAMP_W-1:0] SLOW_LAST = SAMP_W'(SLOW_DIV - 1);
   localparam logic [SAMP_W-1:0] HS_LAST   = SAMP_W'(HS_DIV - 1);

   // Register byte addresses
   localparam logic [31:0] ADDR_RUN  = 32'hFFFF_F1E0;
   localparam logic [31:0] ADDR_STAT = 32'hFFFF_F1E4;
   localparam logic [31:0] ADDR_MODE = 32'hFFFF_F1E8;
   localparam logic [31:0] ADDR_CNT  = 32'hFFFF_F1EC;
   localparam logic [31:0] ADDR_CAP0 = 32'hFFFF_F1F0;
   localparam logic [31:0] ADDR_CAP1 = 32'hFFFF_F1F4;
   localparam logic [31:0] ADDR_CMP  = 32'hFFFF_F1F8;

   // Run register fields
   localparam int RUN_CNT  = 0;
   localparam int RUN_PRE  = 2;
   localparam int RUN_IDLE = 3;
   localparam int RUN_UD   = 4;
   localparam int RUN_SAMP = 5;
   localparam int RUN_DBUF = 7;
   localparam logic [7:0] RUN_WMASK = 8'hFD;
   localparam logic [7:0] RUN_RESET = 8'h00;

   // Mode register fields
   localparam int MODE_CLK   = 0;
   localparam int MODE_CAP   = 2;
   localparam int MODE_SWCAP = 4;
   localparam logic [1:0] CKS_EXT = 2'h0;

   // Status register fields
   localparam int ST_OVF = 2;
   localparam int ST_CNT = 4;

   // Counter values
   localparam logic [15:0] CNT_MID  = 16'h7FFF;
   localparam logic [15:0] CNT_ZERO = 16'h0000;
   localparam logic [15:0] CNT_FULL = 16'hFFFF;

   typedef enum logic [1:0] {CAP_OFF, CAP_IN0_BOTH, CAP_IN0_IN1, CAP_GATE} qcc_cap_e;

   typedef struct packed {
      logic [31:0] paddr;
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [31:0] pwdata;
      logic [3:0]  pstrb;
   } qcc_apb_req_s;

   typedef struct packed {
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } qcc_apb_rsp_s;

endpackage : qcc_pkg

//--- test/qcc_encoder_model.sv
// Two-phase encoder and external pulse source model
`timescale 1ns/1ps
`default_nettype none
module qcc_encoder_model (
   // Clock
   input  wire logic clk_sys,
   // Pins toward the channel
   output var  logic phase_a_in,
   output var  logic phase_b_in,
   output var  logic ext_capture_in0,
   output var  logic ext_capture_in1
);
   initial begin
      {phase_a_in, phase_b_in, ext_capture_in0, ext_capture_in1} = 4'h0;
   end

   // outside controller flags each falling edge of input 0
   int   edge_irq_a_cnt = 0;
   logic in0_q          = 1'b0;
   always @(posedge clk_sys) begin
      in0_q <= ext_capture_in0;
      if (in0_q && !ext_capture_in0) edge_irq_a_cnt++;
   end

   // up order 0,2,3,1,0, down the reverse
   function automatic logic [1:0] nxt(input logic [1:0] s, input logic up);
      case (s)
         2'h0: nxt = up ? 2'h2 : 2'h1;
         2'h2: nxt = up ? 2'h3 : 2'h0;
         2'h3: nxt = up ? 2'h1 : 2'h2;
         default: nxt = up ? 2'h0 : 2'h3;
      endcase
   endfunction : nxt

   // each state held well past one fast sample period
   task automatic step(input logic up);
      @(posedge clk_sys);
      {phase_a_in, phase_b_in} <= nxt({phase_a_in, phase_b_in}, up);
      repeat (10) @(posedge clk_sys);
   endtask : step

   // both phases flip together, deliberately illegal
   task automatic jump;
      @(posedge clk_sys);
      {phase_a_in, phase_b_in} <= ~{phase_a_in, phase_b_in};
      repeat (10) @(posedge clk_sys);
   endtask : jump

   task automatic pulse(input int which);
      @(posedge clk_sys);
      if (which == 0) ext_capture_in0 <= 1'b1;
      else ext_capture_in1 <= 1'b1;
      repeat (8) @(posedge clk_sys);
      if (which == 0) ext_capture_in0 <= 1'b0;
      else ext_capture_in1 <= 1'b0;
      repeat (8) @(posedge clk_sys);
   endtask : pulse
endmodule : qcc_encoder_model
`default_nettype wire

//--- test/qcc_quad_counter_properties.sv
// Port-level checks for the quadrature counter channel
`timescale 1ns/1ps
`default_nettype none
module qcc_quad_counter_properties
   import qcc_pkg::*;
(
   // Clock and reset
   input wire logic         clk_sys,
   input wire logic         rst_n,
   // APB
   input wire qcc_apb_req_s apb_req,
   input wire qcc_apb_rsp_s apb_rsp,
   // Power and events
   input wire logic         idle_mode,
   input wire logic         sleep_mode,
   input wire logic         quad_count_irq,
   input wire logic         wake_req,
   input wire logic         compare_match
);
   logic [7:0] run_sh;
   logic       acc;
   logic       rd_stat;
   logic       rd_run;
   logic       setup_stat;

   assign acc        = apb_req.psel && apb_req.penable;
   assign rd_stat    = acc && !apb_req.pwrite && apb_req.paddr == ADDR_STAT;
   assign rd_run     = acc && !apb_req.pwrite && apb_req.paddr == ADDR_RUN;
   assign setup_stat = apb_req.psel && !apb_req.penable && !apb_req.pwrite && apb_req.paddr == ADDR_STAT;

   // Shadow of software writes, so mode bits are known without peeking inside
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         run_sh <= 8'h00;
      end else if (acc && apb_req.pwrite && apb_req.paddr == ADDR_RUN && apb_req.pstrb[0]) begin
         run_sh <= apb_req.pwdata[7:0] & RUN_WMASK;
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   a_irq_one_cycle: assert property (quad_count_irq |=> !quad_count_irq)
      else $error("count pulse wider than one cycle");
   a_wake_with_irq: assert property (wake_req |-> quad_count_irq)
      else $error("wake request without a count");
   a_sleep_wakes: assert property (quad_count_irq && $past(sleep_mode) |-> wake_req)
      else $error("count in sleep raised no wake request");
   a_irq_needs_updown: assert property (quad_count_irq |-> $past(run_sh[4]))
      else $error("count pulse outside up/down mode");
   a_idle_freeze: assert property (quad_count_irq |-> !$past(idle_mode) || $past(run_sh[3]))
      else $error("count while idle without idle run");
   a_no_compare: assert property (run_sh[4] && $past(run_sh[4]) |-> !compare_match)
      else $error("compare match in up/down mode");
   a_stat_rsv_zero: assert property (rd_stat |-> apb_rsp.prdata[31:5] == 27'h0 && apb_rsp.prdata[1:0] == 2'h0)
      else $error("status reserved bits not zero");
   a_run_bit1_zero: assert property (rd_run |-> apb_rsp.prdata[31:8] == 24'h0 && !apb_rsp.prdata[1])
      else $error("run register read-only bits not zero");
   a_stat_clears: assert property (rd_stat && apb_rsp.prdata[4] ##1 (!apb_req.psel && !quad_count_irq)
      ##1 (setup_stat && !quad_count_irq) |=> !apb_rsp.prdata[4])
      else $error("count flag survived a status read");
endmodule : qcc_quad_counter_properties

bind qcc_quad_counter qcc_quad_counter_properties u_qcc_quad_counter_properties (
   .clk_sys(clk_sys), .rst_n(rst_n), .apb_req(apb_req), .apb_rsp(apb_rsp), .idle_mode(idle_mode),
   .sleep_mode(sleep_mode), .quad_count_irq(quad_count_irq), .wake_req(wake_req), .compare_match(compare_match));
`default_nettype wire

//--- test/qcc_quad_counter_tb.sv
// Self-checking bench for the quadrature counter channel
`timescale 1ns/1ps
`default_nettype none
module qcc_quad_counter_tb
   import qcc_pkg::*;
;
   logic         clk_sys, rst_n, gate, idle, sleep, q_irq, wake, cmp_m, pa, pb, in0, in1, err;
   qcc_apb_req_s req;
   qcc_apb_rsp_s rsp;
   logic [31:0]  rd;
   logic [3:0]   strb;
   int           n_fail, samples_checked, cyc, irq_cnt, wake_cnt, snap;

   qcc_quad_counter u_qcc_quad_counter (.clk_sys(clk_sys), .rst_n(rst_n), .apb_req(req), .apb_rsp(rsp),
      .ext_capture_in0(in0), .ext_capture_in1(in1), .phase_a_in(pa), .phase_b_in(pb),
      .gate_timer_flipflop(gate), .idle_mode(idle), .sleep_mode(sleep), .quad_count_irq(q_irq),
      .wake_req(wake), .compare_match(cmp_m));
   qcc_encoder_model u_qcc_encoder_model (.clk_sys(clk_sys), .phase_a_in(pa), .phase_b_in(pb),
      .ext_capture_in0(in0), .ext_capture_in1(in1));

   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end

   // Whole run needs a few thousand cycles; the ceiling leaves wide margin
   always @(posedge clk_sys) begin
      cyc++;
      if (q_irq === 1'b1) irq_cnt++;
      if (wake === 1'b1) wake_cnt++;
      if (cyc == 20000) begin
         n_fail++;
         wrap_up();
      end
   end

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : wrap_up

   task automatic xfer(input logic wr, input logic [31:0] addr, input logic [31:0] wdata);
      @(posedge clk_sys);
      req <= '{paddr: addr, psel: 1'b1, penable: 1'b0, pwrite: wr, pwdata: wdata, pstrb: strb};
      @(posedge clk_sys);
      req.penable <= 1'b1;
      // Ends when pready is seen; the bench timeout ends a hung wait
      do begin
         @(posedge clk_sys);
      end while (rsp.pready !== 1'b1);
      rd = rsp.prdata;
      err = rsp.pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
   endtask : xfer

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
         n_fail++;
      end
   endtask : chk

   task automatic rchk(input string what, input logic [31:0] addr, input logic [31:0] exp);
      xfer(1'b0, addr, 32'h0);
      chk(what, exp, rd);
   endtask : rchk

   task automatic wr(input logic [31:0] addr, input logic [31:0] d);
      xfer(1'b1, addr, d);
   endtask : wr

   initial begin
      req = '0;
      strb = 4'hF;
      {gate, idle, sleep, rst_n} = 4'h0;
      {n_fail, samples_checked, cyc, irq_cnt, wake_cnt} = '0;
      repeat (3) @(posedge clk_sys);
      rst_n <= 1'b1;
      rchk("run reset", ADDR_RUN, 32'h0);
      rchk("status reset", ADDR_STAT, 32'h0);
      rchk("unmapped", 32'hFFFF_F1FC, 32'h0);
      chk("unmapped error", 32'h1, {31'h0, err});
      wr(ADDR_RUN, 32'hC2);
      rchk("run bits", ADDR_RUN, 32'hC0);
      wr(ADDR_RUN, 32'h00);
      $display("test registers finished");
      wr(ADDR_MODE, 32'h04);
      wr(ADDR_RUN, 32'h01);
      repeat (2) u_qcc_encoder_model.pulse(0);
      rchk("event count", ADDR_CNT, 32'h2);
      rchk("capture0 rise", ADDR_CAP0, 32'h1);
      rchk("capture1 fall", ADDR_CAP1, 32'h2);
      chk("edge irq a", 32'h2, 32'(u_qcc_encoder_model.edge_irq_a_cnt));
      wr(ADDR_MODE, 32'h08);
      u_qcc_encoder_model.pulse(0);
      u_qcc_encoder_model.pulse(1);
      rchk("capture0 in0", ADDR_CAP0, 32'h2);
      rchk("capture1 in1", ADDR_CAP1, 32'h3);
      wr(ADDR_MODE, 32'h0C);
      gate <= 1'b1;
      repeat (4) @(posedge clk_sys);
      u_qcc_encoder_model.pulse(0);
      gate <= 1'b0;
      repeat (4) @(posedge clk_sys);
      rchk("gate rise", ADDR_CAP0, 32'h3);
      rchk("gate fall", ADDR_CAP1, 32'h4);
      wr(ADDR_CMP, 32'h4);
      repeat (3) @(posedge clk_sys);
      chk("normal match", 32'h1, {31'h0, cmp_m});
      $display("test capture finished");
      wr(ADDR_MODE, 32'h04);
      wr(ADDR_RUN, 32'h31);
      rchk("preset", ADDR_CNT, 32'h7FFF);
      snap = irq_cnt;
      repeat (4) u_qcc_encoder_model.step(1'b1);
      rchk("up count", ADDR_CNT, 32'h8003);
      chk("count pulses", 32'h4, 32'(irq_cnt - snap));
      rchk("status", ADDR_STAT, 32'h10);
      rchk("status cleared", ADDR_STAT, 32'h0);
      repeat (5) u_qcc_encoder_model.step(1'b0);
      rchk("down count", ADDR_CNT, 32'h7FFE);
      repeat (2) u_qcc_encoder_model.jump();
      rchk("both changed", ADDR_CNT, 32'h7FFE);
      u_qcc_encoder_model.pulse(0);
      rchk("no ext capture", ADDR_CAP0, 32'h3);
      wr(ADDR_MODE, 32'h14);
      rchk("sw capture", ADDR_CAP0, 32'h7FFE);
      wr(ADDR_CMP, 32'h7FFE);
      repeat (3) @(posedge clk_sys);
      chk("no match", 32'h0, {31'h0, cmp_m});
      strb = 4'h1;
      wr(ADDR_CMP, 32'h0000_0012);
      strb = 4'hF;
      rchk("compare low lane", ADDR_CMP, 32'h7F12);
      $display("test two-phase finished");
      idle <= 1'b1;
      wr(ADDR_RUN, 32'h39);
      u_qcc_encoder_model.step(1'b1);
      rchk("idle run", ADDR_CNT, 32'h7FFF);
      wr(ADDR_RUN, 32'h31);
      u_qcc_encoder_model.step(1'b1);
      u_qcc_encoder_model.step(1'b0);
      rchk("idle frozen", ADDR_CNT, 32'h7FFF);
      idle <= 1'b0;
      sleep <= 1'b1;
      snap = wake_cnt;
      u_qcc_encoder_model.step(1'b1);
      chk("wake", 32'h1, 32'(wake_cnt - snap));
      sleep <= 1'b0;
      rchk("sleep count", ADDR_CNT, 32'h8000);
      // Slow sampling: first tick lands well over a thousand cycles later
      wr(ADDR_RUN, 32'h11);
      u_qcc_encoder_model.step(1'b1);
      rchk("slow not yet", ADDR_CNT, 32'h8000);
      repeat (1600) @(posedge clk_sys);
      rchk("slow sample", ADDR_CNT, 32'h8001);
      // Normal timer from the prescaler, one count per four cycles
      wr(ADDR_RUN, 32'h00);
      wr(ADDR_MODE, 32'h01);
      wr(ADDR_RUN, 32'h05);
      repeat (400) @(posedge clk_sys);
      rchk("prescaler count", ADDR_CNT, 32'h64);
      $display("test power finished");
      wrap_up();
   end
endmodule : qcc_quad_counter_tb
`default_nettype wire

//--- verilog/qcc_quad_counter.sv
// Two-phase up/down counter with edge capture, APB registers
//
// Added by the designer: the APB register port.
`timescale 1ns/1ps
`default_nettype none

//
// How it works
// - Capture mode 11: gate flip-flop rise loads capture0, fall loads capture1.
// - Clock select 00 makes external input 0 rising edges the count clock.
// - Free-running counter: input 0 rise loads capture0, fall loads capture1.
// - Time difference: input 0 rise loads capture0, input 1 rise loads capture1.
// - Two-phase mode changes the counter by exactly one per valid transition.
// - Single-step transitions count; 0,2,3,1,0 counts up, 0,1,3,2,0 counts down; double steps ignored.
// - Each up/down count pulses the count interrupt, including wraps.
// - Overflow wraps to 0000, underflow to FFFF, counting then continues.
// - Status bit 4 count, bit 3 underflow, bit 2 overflow; rest read 0.
// - Reading the status register clears its flags.
// - Run bit 5 picks sampling: 0 slow clock, 1 base clock over four.
// - Run bit 4: 0 normal timer, 1 up/down two-phase counting.
// - Enabling up/down mode loads the counter with 7FFF first.
// - Up/down mode captures only on software request, external triggers ignored.
// - Up/down mode disables the compare match.
// - Inputs sampled by 32 kHz slow clock or fast clock divided by four.
// - In sleep each count raises the interrupt and a wake request.
// - After wake the counter follows the input state present at wake.
// - Run bit 7 double buffer, bit 3 idle run, bit 1 written 0; reset 0.
module qcc_quad_counter
   import qcc_pkg::*;
#(
   parameter int PRESC_W = 8
) (
   // Clock and reset
   input  wire logic         clk_sys,
   input  wire logic         rst_n,
   // APB slave
   input  wire qcc_apb_req_s apb_req,
   output var  qcc_apb_rsp_s apb_rsp,
   // External pins
   input  wire logic         ext_capture_in0,
   input  wire logic         ext_capture_in1,
   input  wire logic         phase_a_in,
   input  wire logic         phase_b_in,
   // From the gating timer and power control
   input  wire logic         gate_timer_flipflop,
   input  wire logic         idle_mode,
   input  wire logic         sleep_mode,
   // Events
   output logic              quad_count_irq,
   output logic              wake_req,
   output logic              compare_match
);

   typedef struct packed {
      logic [7:0]         run;
      logic [1:0]         clock_select;
      qcc_cap_e           capture_mode_sel;
      logic [15:0]        up_counter;
      logic [15:0]        capture_reg0;
      logic [15:0]        capture_reg1;
      logic [15:0]        cmp;
      logic [15:0]        cmp_buf;
      logic [2:0]         flags;
      logic [PRESC_W-1:0] presc;
      logic [SAMP_W-1:0]  samp;
      logic [1:0]         phase_q;
      logic               ud_d;
      logic               in0_s1;
      logic               in0_s2;
      logic               in0_d;
      logic               in1_s1;
      logic               in1_s2;
      logic               in1_d;
      logic               pa_s1;
      logic               pa_s2;
      logic               pb_s1;
      logic               pb_s2;
      logic               gate_d;
      logic [31:0]        prdata;
      logic               irq;
      logic               wake;
      logic               match;
   } qcc_state_s;

   localparam qcc_state_s ST_RESET = '{
      run:              RUN_RESET,
      clock_select:     CKS_EXT,
      capture_mode_sel: CAP_OFF,
      up_counter:       CNT_ZERO,
      capture_reg0:     CNT_ZERO,
      capture_reg1:     CNT_ZERO,
      cmp:              CNT_ZERO,
      cmp_buf:          CNT_ZERO,
      flags:            3'h0,
      presc:            '0,
      samp:             '0,
      phase_q:          2'h0,
      ud_d:             1'b0,
      in0_s1:           1'b0,
      in0_s2:           1'b0,
      in0_d:            1'b0,
      in1_s1:           1'b0,
      in1_s2:           1'b0,
      in1_d:            1'b0,
      pa_s1:            1'b0,
      pa_s2:            1'b0,
      pb_s1:            1'b0,
      pb_s2:            1'b0,
      gate_d:           1'b0,
      prdata:           32'h0000_0000,
      irq:              1'b0,
      wake:             1'b0,
      match:            1'b0
   };

   qcc_state_s         st;
   qcc_state_s         next_st;

   logic               setup;
   logic               access;
   logic               hit;
   logic               wr;
   logic               sw_cap;
   logic               ud;
   logic               hold;
   logic               in0_rise;
   logic               in0_fall;
   logic               in1_rise;
   logic               gate_rise;
   logic               gate_fall;
   logic               ptick;
   logic               stick;
   logic               ntick;
   logic               cmp_hit;
   logic [1:0]         phase_now;
   logic [1:0]         dir;
   logic [2:0]         set_f;
   logic [2:0]         clr_f;
   logic [SAMP_W-1:0]  samp_last;
   logic [PRESC_W-1:0] pmask;
   logic [PRESC_W-1:0] ones;
   logic [31:0]        rdata;

   // Returns {up, down} for one sampled step of the phase pair
   function automatic logic [1:0] step_dir(input logic [1:0] was, input logic [1:0] now);
      logic [1:0] d;
      d = 2'b00;
      case ({was, now})
         4'b0010, 4'b1011, 4'b1101, 4'b0100: d = 2'b10;
         4'b0001, 4'b0111, 4'b1110, 4'b1000: d = 2'b01;
         default: d = 2'b00;
      endcase
      return d;
   endfunction : step_dir

   // Byte-lane merge for 16-bit registers
   function automatic logic [15:0] lane16(input logic [15:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
      logic [15:0] r;
      r = old;
      if (be[0]) begin
         r[7:0] = wd[7:0];
      end
      if (be[1]) begin
         r[15:8] = wd[15:8];
      end
      return r;
   endfunction : lane16

   always_comb begin
      next_st   = st;
      next_st.irq  = 1'b0;
      next_st.wake = 1'b0;

      // Pins pass two flops before use
      next_st.in0_s1 = ext_capture_in0;
      next_st.in0_s2 = st.in0_s1;
      next_st.in0_d  = st.in0_s2;
      next_st.in1_s1 = ext_capture_in1;
      next_st.in1_s2 = st.in1_s1;
      next_st.in1_d  = st.in1_s2;
      next_st.pa_s1  = phase_a_in;
      next_st.pa_s2  = st.pa_s1;
      next_st.pb_s1  = phase_b_in;
      next_st.pb_s2  = st.pb_s1;
      next_st.gate_d = gate_timer_flipflop;

      in0_rise  = st.in0_s2 & ~st.in0_d;
      in0_fall  = ~st.in0_s2 & st.in0_d;
      in1_rise  = st.in1_s2 & ~st.in1_d;
      gate_rise = gate_timer_flipflop & ~st.gate_d;
      gate_fall = ~gate_timer_flipflop & st.gate_d;

      // APB decode, zero wait states
      setup  = apb_req.psel & ~apb_req.penable;
      access = apb_req.psel & apb_req.penable;
      hit    = (apb_req.paddr == ADDR_RUN) || (apb_req.paddr == ADDR_STAT) ||
               (apb_req.paddr == ADDR_MODE) || (apb_req.paddr == ADDR_CNT) ||
               (apb_req.paddr == ADDR_CAP0) || (apb_req.paddr == ADDR_CAP1) ||
               (apb_req.paddr == ADDR_CMP);
      wr     = access & apb_req.pwrite & hit;
      sw_cap = wr & apb_req.pstrb[0] & (apb_req.paddr == ADDR_MODE) &
               apb_req.pwdata[MODE_SWCAP];

      ud   = st.run[RUN_UD];
      hold = idle_mode & ~st.run[RUN_IDLE];

      // Prescaler: select n divides by four to the power n
      ones    = '1;
      pmask   = ~(ones << {st.clock_select, 1'b0});
      ptick   = st.run[RUN_PRE] & ((st.presc & pmask) == pmask);
      next_st.presc = st.run[RUN_PRE] ? PRESC_W'(st.presc + 1'b1) : '0;

      samp_last = st.run[RUN_SAMP] ? HS_LAST : SLOW_LAST;
      stick     = ud & (st.samp >= samp_last);
      if (!ud || stick) begin
         next_st.samp = '0;
      end else begin
         next_st.samp = SAMP_W'(st.samp + 1'b1);
      end

      // each sample compares against the last seen state
      phase_now = {st.pa_s2, st.pb_s2};
      dir       = stick ? step_dir(st.phase_q, phase_now) : 2'b00;
      set_f     = 3'b000;
      if (stick) begin
         next_st.phase_q = phase_now;
      end

      next_st.ud_d = ud;
      if (ud && !st.ud_d) begin
         next_st.up_counter = CNT_MID;
         next_st.phase_q    = phase_now;
      end else if (ud) begin
         if (!hold && dir != 2'b00) begin
            if (dir[1]) begin
               next_st.up_counter = 16'(st.up_counter + 1'b1);
            end else begin
               next_st.up_counter = 16'(st.up_counter - 1'b1);
            end
            set_f[0] = dir[1] & (st.up_counter == CNT_FULL);
            set_f[1] = dir[0] & (st.up_counter == CNT_ZERO);
            set_f[2]     = 1'b1;
            next_st.irq  = 1'b1;
            // count in sleep wakes the system
            next_st.wake = sleep_mode;
         end
      end else if (!st.run[RUN_CNT]) begin
         next_st.up_counter = CNT_ZERO;
      end else if (!hold) begin
         // external input 0 as count clock at select 00, else the prescaler
         ntick = (st.clock_select == CKS_EXT) ? in0_rise : ptick;
         if (ntick) begin
            next_st.up_counter = 16'(st.up_counter + 1'b1);
         end
      end
      ntick = 1'b0;

      // external triggers only outside up/down mode
      if (!ud) begin
         case (st.capture_mode_sel)
            CAP_IN0_BOTH: begin
               if (in0_rise) begin
                  next_st.capture_reg0 = st.up_counter;
               end
               if (in0_fall) begin
                  next_st.capture_reg1 = st.up_counter;
               end
            end
            CAP_IN0_IN1: begin
               if (in0_rise) begin
                  next_st.capture_reg0 = st.up_counter;
               end
               if (in1_rise) begin
                  next_st.capture_reg1 = st.up_counter;
               end
            end
            CAP_GATE: begin
               if (gate_rise) begin
                  next_st.capture_reg0 = st.up_counter;
               end
               if (gate_fall) begin
                  next_st.capture_reg1 = st.up_counter;
               end
            end
            default: begin
            end
         endcase
      end
      if (sw_cap) begin
         next_st.capture_reg0 = st.up_counter;
      end

      // compare only in normal timer operation
      cmp_hit       = ~ud & st.run[RUN_CNT] & (st.up_counter == st.cmp);
      next_st.match = cmp_hit;
      if (cmp_hit && st.run[RUN_DBUF]) begin
         next_st.cmp = st.cmp_buf;
      end

      // Read mux, sampled in the setup phase
      rdata = 32'h0000_0000;
      case (apb_req.paddr)
         ADDR_RUN:  rdata[7:0] = st.run;
         // flags in bits 4..2, rest zero
         ADDR_STAT: rdata[ST_CNT:ST_OVF] = st.flags;
         ADDR_MODE: rdata[MODE_CAP+1:MODE_CLK] = {st.capture_mode_sel, st.clock_select};
         ADDR_CNT:  rdata[15:0] = st.up_counter;
         ADDR_CAP0: rdata[15:0] = st.capture_reg0;
         ADDR_CAP1: rdata[15:0] = st.capture_reg1;
         ADDR_CMP:  rdata[15:0] = st.cmp;
         default:   rdata = 32'h0000_0000;
      endcase
      if (setup) begin
         next_st.prdata = rdata;
      end

      // clear only what the read returned; a new event wins
      clr_f = 3'b000;
      if (access && !apb_req.pwrite && apb_req.paddr == ADDR_STAT) begin
         clr_f = st.prdata[ST_CNT:ST_OVF];
      end
      next_st.flags = (st.flags & ~clr_f) | set_f;

      if (wr) begin
         case (apb_req.paddr)
            ADDR_RUN: begin
               if (apb_req.pstrb[0]) begin
                  next_st.run = apb_req.pwdata[7:0] & RUN_WMASK;
               end
            end
            ADDR_MODE: begin
               if (apb_req.pstrb[0]) begin
                  next_st.clock_select     = apb_req.pwdata[MODE_CLK+1:MODE_CLK];
                  next_st.capture_mode_sel = qcc_cap_e'(apb_req.pwdata[MODE_CAP+1:MODE_CAP]);
               end
            end
            ADDR_CMP: begin
               // Buffered write lands at the next match
               next_st.cmp_buf = lane16(st.cmp_buf, apb_req.pwdata, apb_req.pstrb);
               if (!st.run[RUN_DBUF]) begin
                  next_st.cmp = lane16(st.cmp, apb_req.pwdata, apb_req.pstrb);
               end
            end
            default: begin
            end
         endcase
      end

      apb_rsp.prdata  = st.prdata;
      apb_rsp.pready  = access;
      apb_rsp.pslverr = access & ~hit;
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         st <= ST_RESET;
      end else begin
         st <= next_st;
      end
   end

   assign quad_count_irq = st.irq;
   assign wake_req       = st.wake;
   assign compare_match  = st.match;

endmodule : qcc_quad_counter

`default_nettype wire
